// ===== rtl/byte_skid_buffer.sv
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_skid_buffer
(
   input  wire logic       clk,
   input  wire logic       rstSyncN,
   input  wire logic [7:0] inData,
   input  wire logic       inValid,
   output var  logic       inReady,
   output var  logic [7:0] outData,
   output var  logic       outValid,
   input  wire logic       outReady
);
   logic [7:0] slot_r [2];
   logic [1:0] count_r;
   logic       rdIdx_r;
   logic       wrIdx_r;
   wire        doPush = inValid && inReady;
   wire        doPop  = outValid && outReady;

   assign inReady  = (count_r != 2'h2);
   assign outValid = (count_r != 2'h0);
   assign outData  = slot_r[rdIdx_r];

   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         count_r <= 2'h0;
         rdIdx_r <= 1'b0;
         wrIdx_r <= 1'b0;
         slot_r[0] <= 8'h00;
         slot_r[1] <= 8'h00;
      end
      else
      begin
         if (doPush)
         begin
            slot_r[wrIdx_r] <= inData;
            wrIdx_r <= ~wrIdx_r;
         end
         if (doPop)
            rdIdx_r <= ~rdIdx_r;
         count_r <= count_r + {1'b0, doPush} - {1'b0, doPop};
      end
   end
endmodule : byte_skid_buffer
`default_nettype wire

// ===== rtl/fdc_cmd_engine.sv
// Command interpreter: read identifier, verify, version, write commands
`timescale 1ns/10ps
`default_nettype none
module fdc_cmd_engine
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] cmdByte,
   input  wire logic       cmdValid,
   output var  logic       cmdReady,
   output var  logic [7:0] resultByte,
   output var  logic       resultValid,
   input  wire logic       resultReady,
   input  wire logic [7:0] hostData,
   input  wire logic       hostDataValid,
   output var  logic       hostDataReady,
   output var  logic [7:0] diskData,
   output var  logic       diskDataValid,
   input  wire logic       diskDataReady,
   output var  logic       execStart,
   output var  logic       execWrite,
   output var  logic       execReadId,
   output var  logic       deletedMark,
   output var  logic       multitrack_flag,
   output var  logic       density_select,
   output var  logic       skip_deleted_flag,
   output var  logic       enable_count_flag,
   output var  logic       head_select,
   output var  logic       drive_select_hi,
   output var  logic       drive_select_lo,
   output var  logic [7:0] last_sector_number,
   output var  logic [7:0] gap_length,
   output var  logic [7:0] data_length,
   input  wire logic       sectorDeleted,
   input  wire logic       sectorNext,
   input  wire logic       execDone,
   input  wire logic [7:0] status_byte_0,
   input  wire logic [7:0] status_byte_1,
   input  wire logic [7:0] status_byte_2,
   input  wire logic [7:0] idCyl,
   input  wire logic [7:0] idHead,
   input  wire logic [7:0] idSector,
   input  wire logic [7:0] idSize,
   output var  logic       busy
);
   import fdc_cmd_pkg::*;

   // ========================================
   // Reset release
   logic [1:0] rstPipe_r;
   wire        rstSyncN = rstPipe_r[1];
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rstPipe_r <= 2'b00;
      else
         rstPipe_r <= {rstPipe_r[0], 1'b1};
   end

   // ========================================
   // Command decode
   phase_t     phase_r;
   logic [7:0] opcode_r;
   logic [7:0] par_r [9];
   logic [3:0] parIdx_r;
   logic [3:0] parNeed_r;
   logic [2:0] resIdx_r;
   logic [2:0] resNeed_r;
   logic [7:0] res_r [7];
   logic [15:0] byteCnt_r;
   logic       resultOut_r;

   wire        cmdTake   = cmdValid && cmdReady;
   wire        isReadId  = (cmdByte[4:0] == OP_READ_ID) && !cmdByte[7]
                           && !cmdByte[SKIP_BIT];
   wire        isVerify  = (cmdByte[4:0] == OP_VERIFY);
   wire        isWrite   = (cmdByte[4:0] == OP_WRITE)
                           && !cmdByte[SKIP_BIT];
   wire        isWrDel   = (cmdByte[4:0] == OP_WRITE_DEL)
                           && !cmdByte[SKIP_BIT];
   wire        isVersion = (cmdByte == OP_VERSION);
   wire        opWrite   = (opcode_r[4:0] == OP_WRITE)
                           || (opcode_r[4:0] == OP_WRITE_DEL);
   wire        opReadId  = (opcode_r[4:0] == OP_READ_ID);
   // Size code bounds the sector: 128 << N bytes, capped at code 7
   // Slots: 2 cyl, 3 head, 4 sector, 5 size, 6 last, 7 gap, 8 length
   wire [2:0]  sizeCode  = (par_r[5] > 8'h07) ? 3'h7 : par_r[5][2:0];
   wire [15:0] sectorLen = 16'(SIZE_BASE) << sizeCode;
   // Nonzero data length with size code 0 trims the short sector
   wire [15:0] sectorLim = (par_r[5] == 8'h00 && par_r[8] != 8'h00)
                           ? {8'h00, par_r[8]} : sectorLen;
   wire        lastByte  = (byteCnt_r == sectorLim - 16'h0001);

   // Buffer between host data and disk write path
   logic       bufInValid;
   logic       bufInReady;
   assign bufInValid    = (phase_r == S_DATA) && hostDataValid;
   assign hostDataReady = (phase_r == S_DATA) && bufInReady;
   wire        dataTake = bufInValid && bufInReady;

   byte_skid_buffer u_buf
   (
      .clk      (core_clk),
      .rstSyncN (rstSyncN),
      .inData   (hostData),
      .inValid  (bufInValid),
      .inReady  (bufInReady),
      .outData  (diskData),
      .outValid (diskDataValid),
      .outReady (diskDataReady)
   );

   assign cmdReady    = (phase_r == S_IDLE) || (phase_r == S_PARAM);
   assign resultValid = resultOut_r;
   assign resultByte  = res_r[resIdx_r];
   assign busy        = (phase_r != S_IDLE);

   assign multitrack_flag   = opcode_r[MT_BIT];
   assign density_select    = opcode_r[DENS_BIT];
   assign skip_deleted_flag = opcode_r[SKIP_BIT];
   assign enable_count_flag = par_r[1][EC_BIT];
   assign head_select       = par_r[1][HEAD_BIT];
   assign drive_select_hi   = par_r[1][1];
   assign drive_select_lo   = par_r[1][0];
   assign last_sector_number = par_r[6];
   assign gap_length        = par_r[7];
   assign data_length       = par_r[8];
   assign execWrite         = opWrite;
   assign execReadId        = opReadId;
   assign deletedMark       = (opcode_r[4:0] == OP_WRITE_DEL);

   // ========================================
   // Sequencer
   always_ff @(posedge core_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         phase_r     <= S_IDLE;
         opcode_r    <= 8'h00;
         parIdx_r    <= 4'h0;
         parNeed_r   <= 4'h0;
         resIdx_r    <= 3'h0;
         resNeed_r   <= 3'h0;
         byteCnt_r   <= 16'h0000;
         resultOut_r <= 1'b0;
         execStart   <= 1'b0;
         for (int i = 0; i < 9; i++)
            par_r[i] <= 8'h00;
         for (int i = 0; i < 7; i++)
            res_r[i] <= 8'h00;
      end
      else
      begin
         execStart <= 1'b0;
         case (phase_r)
            S_IDLE:
               if (cmdTake)
               begin
                  opcode_r <= cmdByte;
                  par_r[0] <= cmdByte;
                  parIdx_r <= 4'h1;
                  resIdx_r <= 3'h0;
                  if (isVersion)
                  begin
                     res_r[0]    <= VERSION_ANSWER;
                     resNeed_r   <= 3'h1;
                     resultOut_r <= 1'b1;
                     phase_r     <= S_RESULT;
                  end
                  else if (isReadId)
                  begin
                     parNeed_r <= PARAMS_SHORT;
                     phase_r   <= S_PARAM;
                  end
                  else if (isVerify || isWrite || isWrDel)
                  begin
                     parNeed_r <= PARAMS_FULL;
                     phase_r   <= S_PARAM;
                  end
                  else
                  begin
                     // Unknown opcodes answer a single invalid status
                     res_r[0]    <= ST0_INVALID;
                     resNeed_r   <= 3'h1;
                     resultOut_r <= 1'b1;
                     phase_r     <= S_RESULT;
                  end
               end
            S_PARAM:
               if (cmdTake)
               begin
                  par_r[parIdx_r] <= cmdByte;
                  parIdx_r        <= parIdx_r + 4'h1;
                  if (parIdx_r == parNeed_r - 4'h1)
                  begin
                     execStart <= 1'b1;
                     byteCnt_r <= 16'h0000;
                     phase_r   <= opWrite ? S_DATA : S_EXEC;
                  end
               end
            S_DATA:
               if (execDone)
                  phase_r <= S_EXEC;
               else if (sectorNext)
                  byteCnt_r <= 16'h0000;
               else if (dataTake && lastByte)
                  phase_r <= S_EXEC;
               else if (dataTake)
                  byteCnt_r <= byteCnt_r + 16'h0001;
            S_EXEC:
               if (execDone)
               begin
                  // Status first, then the identifier reached
                  res_r[0]    <= status_byte_0;
                  res_r[1]    <= status_byte_1;
                  res_r[2]    <= status_byte_2;
                  res_r[3]    <= idCyl;
                  res_r[4]    <= idHead;
                  res_r[5]    <= idSector;
                  res_r[6]    <= idSize;
                  resNeed_r   <= RESULTS_FULL;
                  resultOut_r <= 1'b1;
                  phase_r     <= S_RESULT;
               end
               else if (opWrite && sectorNext && !diskDataValid)
               begin
                  // Never skips: writes with the skip bit set are refused at decode, so the flag is clear here
                  if (!(skip_deleted_flag && sectorDeleted))
                  begin
                     byteCnt_r <= 16'h0000;
                     phase_r   <= S_DATA;
                  end
               end
            S_RESULT:
               if (resultValid && resultReady)
               begin
                  if (resIdx_r == resNeed_r - 3'h1)
                  begin
                     resultOut_r <= 1'b0;
                     phase_r     <= S_IDLE;
                  end
                  else
                     resIdx_r <= resIdx_r + 3'h1;
               end
            default:
               phase_r <= S_IDLE;
         endcase
      end
   end
endmodule : fdc_cmd_engine
`default_nettype wire

// ===== rtl/fdc_cmd_pkg.sv
// Constants for the disk command interpreter
package fdc_cmd_pkg;
   localparam logic [4:0] OP_READ_ID     = 5'h0a;
   localparam logic [4:0] OP_VERIFY      = 5'h16;
   localparam logic [4:0] OP_WRITE       = 5'h05;
   localparam logic [4:0] OP_WRITE_DEL   = 5'h09;
   localparam logic [7:0] OP_VERSION     = 8'h10;
   localparam logic [7:0] VERSION_ANSWER = 8'h90;
   localparam int MT_BIT   = 7;
   localparam int DENS_BIT = 6;
   localparam int SKIP_BIT = 5;
   localparam int EC_BIT   = 7;
   localparam int HEAD_BIT = 2;
   localparam logic [3:0] PARAMS_FULL  = 4'h9;
   localparam logic [3:0] PARAMS_SHORT = 4'h2;
   localparam logic [2:0] RESULTS_FULL = 3'h7;
   localparam logic [7:0] ST0_INVALID  = 8'h80;
   localparam logic [7:0] SIZE_BASE    = 8'h80;
   typedef enum logic [2:0] {
      S_IDLE, S_PARAM, S_EXEC, S_DATA, S_RESULT
   } phase_t;
endpackage : fdc_cmd_pkg

// ===== verification/disk_side_model.sv
// Disk-side stand-in: stalls the byte stream and ends each command
`timescale 1ns/10ps
`default_nettype none
module disk_side_model
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        execStart,
   input  wire logic        execWrite,
   input  wire logic [7:0]  diskData,
   input  wire logic        diskDataValid,
   output var  logic        diskDataReady,
   output var  logic        execDone,
   output var  logic [31:0] got
);
   logic [1:0] tick_r;
   logic [2:0] cnt_r;
   logic       go_r;
   // Ready one cycle in four so the two-entry buffer really fills
   assign diskDataReady = (tick_r == 2'h3);
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
      begin
         tick_r <= 2'h0;
         cnt_r <= 3'h0;
         go_r <= 1'b0;
         execDone <= 1'b0;
         got <= 32'h0;
      end
      else
      begin
         tick_r <= tick_r + 2'h1;
         execDone <= 1'b0;
         if (diskDataValid && diskDataReady)
         begin
            got <= {got[23:0], diskData};
            cnt_r <= cnt_r + 3'h1;
         end
         if (execStart)
         begin
            go_r <= 1'b1;
            cnt_r <= 3'h0;
         end
         else if (go_r && (!execWrite || cnt_r == 3'h4))
         begin
            go_r <= 1'b0;
            execDone <= 1'b1;
         end
      end
endmodule : disk_side_model
`default_nettype wire

// ===== verification/fdc_cmd_chk.sv
// Port assertions for the disk command interpreter
`timescale 1ns/10ps
`default_nettype none
module fdc_cmd_chk
   import fdc_cmd_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       cmdValid,
   input wire logic       cmdReady,
   input wire logic       busy,
   input wire logic       resultValid,
   input wire logic       resultReady,
   input wire logic       hostDataValid,
   input wire logic       hostDataReady,
   input wire logic       diskDataValid,
   input wire logic       diskDataReady,
   input wire logic       execStart,
   input wire logic       execWrite,
   input wire logic       execDone,
   input wire logic       deletedMark,
   input wire logic       multitrack_flag,
   input wire logic       density_select,
   input wire logic       skip_deleted_flag,
   input wire logic [7:0] cmdByte,
   input wire logic [7:0] resultByte,
   input wire logic [7:0] diskData,
   input wire logic [7:0] status_byte_0
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ======================================================
   // Command steps
   sequence opTake;
      cmdValid && cmdReady && !busy;
   endsequence
   sequence paramTake;
      cmdValid && cmdReady;
   endsequence
   sequence writeOpTake;
      opTake ##0 (cmdByte[4:0] == OP_WRITE || cmdByte[4:0] == OP_WRITE_DEL);
   endsequence
   a_version_answer: assert property (
      opTake ##0 (cmdByte == OP_VERSION)
      |-> ##[1:2] resultValid && resultByte == VERSION_ANSWER)
      else $error("version answer wrong");
   a_readid_start: assert property (
      opTake ##0 (cmdByte[4:0] == OP_READ_ID) ##1 paramTake |=> execStart)
      else $error("read id did not start");
   a_flags_taken: assert property (
      opTake ##0 (cmdByte[4:0] == OP_VERIFY)
      |=> {multitrack_flag, density_select, skip_deleted_flag}
      == $past(cmdByte[7:5]))
      else $error("verify flags not taken");
   a_status_first: assert property (
      execDone |=> resultValid && resultByte == $past(status_byte_0))
      else $error("first result wrong");
   a_start_pulse: assert property (
      execStart |=> !execStart)
      else $error("start longer than one cycle");
   a_deleted_write: assert property (
      writeOpTake |=> execWrite
      && deletedMark == $past(cmdByte[4:0] == OP_WRITE_DEL))
      else $error("deleted mark does not follow opcode");
   a_verify_nodata: assert property (
      busy && !execWrite |-> !hostDataReady)
      else $error("data accepted without a write");
   a_disk_follows: assert property (
      hostDataValid && hostDataReady |=> diskDataValid)
      else $error("taken byte not offered");
   a_disk_holds: assert property (
      diskDataValid && !diskDataReady |=> diskDataValid && $stable(diskData))
      else $error("disk byte lost");
   a_result_holds: assert property (
      resultValid && !resultReady
      |=> resultValid && $stable(resultByte))
      else $error("result byte lost");
endmodule : fdc_cmd_chk
bind fdc_cmd_engine fdc_cmd_chk chk_u (.*);
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the disk command interpreter
`timescale 1ns/10ps
`default_nettype none
module tb;
   import fdc_cmd_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, cmdValid = 1'b0;
   logic resultReady = 1'b0, hostDataValid = 1'b0;
   logic [7:0] cmdByte = 8'h00, hostData = 8'h00, base = 8'h20;
   logic [7:0] wr [9], vfy [9];
   logic [31:0] got;
   wire logic cmdReady, resultValid, hostDataReady, diskDataValid, busy;
   wire logic diskDataReady, execStart, execWrite, execReadId, deletedMark;
   wire logic multitrack_flag, density_select, skip_deleted_flag, execDone;
   wire logic enable_count_flag, head_select, drive_select_hi, drive_select_lo;
   wire logic [7:0] resultByte, diskData, last_sector_number, gap_length;
   wire logic [7:0] data_length;
   int errorCnt = 0, nCompared = 0, cyc = 0;
   always #10 core_clk = ~core_clk;
   fdc_cmd_engine dut_u (.*, .sectorDeleted(1'b0), .sectorNext(1'b0),
      .status_byte_0(base), .status_byte_1(base + 8'h01),
      .status_byte_2(base + 8'h02), .idCyl(base + 8'h03),
      .idHead(base + 8'h04), .idSector(base + 8'h05), .idSize(base + 8'h06));
   disk_side_model disk_u (.*);
   // ======================================================
   // Access tasks
   task automatic check(input logic [31:0] g, e, input string what);
      nCompared++;
      if (g !== e)
      begin
         errorCnt++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask : check
   // Leaves cmdValid high so bytes can go back to back
   task automatic send(input logic [7:0] b);
      cmdValid <= 1'b1;
      cmdByte <= b;
      for (int t = 0; t < 200; t++)
      begin
         @(negedge core_clk);
         if (cmdReady === 1'b1) break;
      end
      @(posedge core_clk);
   endtask : send
   task automatic sendData(input logic [7:0] b);
      hostDataValid <= 1'b1;
      hostData <= b;
      for (int t = 0; t < 200; t++)
      begin
         @(negedge core_clk);
         if (hostDataReady === 1'b1) break;
      end
      @(posedge core_clk);
   endtask : sendData
   task automatic results(input int n, input logic [7:0] single);
      repeat (2) @(posedge core_clk);
      resultReady <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         for (int t = 0; t < 200; t++)
         begin
            @(negedge core_clk);
            if (resultValid === 1'b1) break;
         end
         check(resultByte, (n == 1) ? single : base + 8'(i), "result");
         @(posedge core_clk);
      end
      resultReady <= 1'b0;
      $display("test done, %0d result bytes", n);
   endtask : results
   task automatic endOfTest;
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : endOfTest
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errorCnt++;
         endOfTest();
      end
   end
   // ======================================================
   // Tests
   initial
   begin
      vfy = '{8'hf6, 8'h86, 8'h01, 8'h01, 8'h01, 8'h02, 8'h09, 8'h1b, 8'h03};
      wr = '{8'h45, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00, 8'h05, 8'h1b, 8'h04};
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      send(OP_VERSION);
      cmdValid <= 1'b0;
      results(1, 8'h90);
      send(8'h00);
      cmdValid <= 1'b0;
      results(1, 8'h80);
      base <= 8'h30;
      send(8'h4a);
      send(8'h05);
      cmdValid <= 1'b0;
      @(negedge core_clk);
      check({density_select, head_select, drive_select_hi, drive_select_lo,
         execReadId}, 5'h1b, "id fields");
      results(7, 8'h00);
      base <= 8'h40;
      foreach (vfy[i]) send(vfy[i]);
      cmdValid <= 1'b0;
      @(negedge core_clk);
      check({multitrack_flag, density_select, skip_deleted_flag,
         enable_count_flag, head_select, drive_select_hi, drive_select_lo},
         7'h7e, "verify flags");
      check({last_sector_number, gap_length, data_length}, 24'h091b03,
         "verify params");
      results(7, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         base <= 8'h50 + 8'(k * 16);
         wr[0] = k ? 8'h49 : 8'h45;
         foreach (wr[i]) send(wr[i]);
         cmdValid <= 1'b0;
         for (int i = 0; i < 4; i++) sendData(base + 8'(i));
         hostDataValid <= 1'b0;
         @(negedge core_clk);
         check({deletedMark, execWrite}, {k[0], 1'b1}, "mark");
         check({last_sector_number, gap_length, data_length}, 24'h051b04,
            "write params");
         results(7, 8'h00);
         check(got, {base, base + 8'h01, base + 8'h02, base + 8'h03},
            "disk bytes");
      end
      endOfTest();
   end
endmodule : tb
`default_nettype wire
